// ### rtl/odr_pkg.sv
// Register map, field positions and timing constants of the session block.
package odr_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] STAT_OFS  = 8'h04;
  localparam logic [7:0] EVT_OFS   = 8'h08;
  localparam logic [7:0] MASK_OFS  = 8'h0C;
  localparam logic [7:0] TMR_OFS   = 8'h10;
  // Control register fields.
  localparam int C_VBUS_DRV   = 0;
  localparam int C_VBUS_CHG   = 1;
  localparam int C_VBUS_DRAIN = 2;
  localparam int C_DP_PULLUP  = 4;
  localparam int C_HNP_REL    = 5;
  localparam int C_SRP_SEL    = 9;
  localparam int C_SRP_EN     = 10;
  localparam int CTRL_W       = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  // Status register fields; bits 0..4 also raise change events.
  localparam int S_ID        = 0;
  localparam int S_AVBUS     = 1;
  localparam int S_BSEND     = 2;
  localparam int S_ASESS     = 3;
  localparam int S_BSESS     = 4;
  localparam int S_SE0LONG   = 5;
  localparam int S_SUSPEND   = 6;
  localparam int S_SRPDET    = 7;
  localparam int S_HOST      = 8;
  localparam int S_SINGLE_ENDED_ZERO_LONG_FLAG   = 9;
  localparam int S_DP        = 10;
  localparam int S_DM        = 11;
  localparam int CHG_W       = 5;
  // Event register fields.
  localparam int E_SE0LONG   = 5;
  localparam int E_SUSPEND   = 6;
  localparam int E_RESUME    = 7;
  localparam int E_SRPDET    = 8;
  localparam int E_TIMER     = 9;
  localparam int EVT_W       = 10;
  localparam logic [EVT_W-1:0] EVT_RST  = 10'h000;
  localparam logic [EVT_W-1:0] MASK_RST = 10'h000;
  // Timer register fields.
  localparam int T_RUN       = 16;
  localparam int TMR_W       = 16;
  // Timing: one tick is 10 us of a 100 MHz clock.
  localparam int CLK_MHZ     = 100;
  localparam int TICK_US     = 10;
  localparam int TICK_CYC    = TICK_US * CLK_MHZ;
  localparam int SE0_LONG_MS = 2;
  localparam int SUSPEND_MS  = 3;
  localparam int SE0_LONG_TK = SE0_LONG_MS * 1000 / TICK_US;
  localparam int SUSPEND_TK  = SUSPEND_MS * 1000 / TICK_US;
endpackage : odr_pkg

// ### rtl/odr_chg_det.sv
// Change detector that pulses when any bit of a level vector toggles.
`timescale 1ns/1ps
module odr_chg_det #(
  parameter int WIDTH = 5
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] changed
);
  logic [WIDTH-1:0] prev_r;
  logic             armed_r;

  // The first sample after reset only arms the detector.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_r  <= '0;
      armed_r <= 1'b0;
    end else begin
      prev_r  <= level;
      armed_r <= 1'b1;
    end
  end

  assign changed = armed_r ? (prev_r ^ level) : '0;
endmodule // odr_chg_det

// ### rtl/odr_session_ctl.sv
// Dual-role session control: role, SRP detect, line timers, APB registers.
// Functional notes
// R1 - ID low A-host, ID high B-peripheral
// R2 - Session spans VBUS driven until off
// R3 - B-device with session valid connects pull-up
// R4 - A-device drives VBUS, becomes host
// R5 - Only A-device sources VBUS, B charges
// R6 - Software checks ID, session end, SE0
// R7 - Software pulses DP pull-up 5-10 ms
// R8 - Software charges VBUS 10-20 ms
// R9 - Optional VBUS drain about 30 ms
// R10 - Whole session request within 100 ms
// R11 - Select bit picks VBUS or line detection
// R12 - Enable bit gates session-request detection
// R13 - Line detection accepts DP or DM pulse
// R14 - Own line pulsing only on DP
// R15 - A hands off by enable then suspend
// R16 - B drops pull-up after 5 ms idle
// R17 - A connects pull-up after SE0 seen
// R18 - B waits then drives reset as host
// R19 - B host stops, may reconnect pull-up
// R20 - A drops pull-up after 3 ms idle
// R21 - A sees J then takes host role
// R22 - One programmable timer, restart per state
// R23 - Bus-derived inputs visible in status/events
// R24 - Timer counts 10 us, expiry raises event
// R25 - Masked events drive shared interrupt pin
`timescale 1ns/1ps
module odr_session_ctl (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        plug_id_pin,
  input  wire logic        a_vbus_valid,
  input  wire logic        a_sess_valid,
  input  wire logic        b_sess_valid,
  input  wire logic        b_sess_end,
  input  wire logic        dp_in,
  input  wire logic        dm_in,
  output logic             vbus_drive_en,
  output logic             vbus_charge_en,
  output logic             vbus_drain_en,
  output logic             dp_pullup_en,
  output logic             role_host,
  output logic             host_side_irq_pin
);
  ////////////////////////////////////////////////////////////////////////////
  logic [odr_pkg::CTRL_W-1:0] dual_role_control_reg_r;
  logic [odr_pkg::EVT_W-1:0]  dual_role_event_reg_r;
  logic [odr_pkg::EVT_W-1:0]  dual_role_event_mask_reg_r;
  logic [odr_pkg::EVT_W-1:0]  evt_set;
  logic [odr_pkg::EVT_W-1:0]  evt_nxt;
  logic [odr_pkg::TMR_W-1:0]  tmr_load_r;
  logic [odr_pkg::TMR_W-1:0]  tmr_cnt_r;
  logic                       tmr_run_r;
  logic                       tmr_done;
  logic [9:0]                 div_cnt_r;
  logic                       tick;
  logic [9:0]                 se0_cnt_r;
  logic [9:0]                 idle_cnt_r;
  logic                       se0_long_r;
  logic                       suspend_r;
  logic                       srp_det_r;
  logic                       srp_hit;
  logic                       asess_q_r;
  logic                       se0;
  logic                       jstate;
  logic [odr_pkg::CHG_W-1:0]  lvl;
  logic [odr_pkg::CHG_W-1:0]  lvl_chg;
  logic [31:0]                status;
  logic [31:0]                rd_nxt;
  logic                       wr_acc;
  logic                       bad_addr;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped offsets answer with pslverr.
  assign pready   = 1'b1;
  assign bad_addr = !(paddr == odr_pkg::CTRL_OFS || paddr == odr_pkg::STAT_OFS
                   || paddr == odr_pkg::EVT_OFS || paddr == odr_pkg::MASK_OFS
                   || paddr == odr_pkg::TMR_OFS);
  assign pslverr  = psel && penable && bad_addr;
  assign wr_acc   = psel && penable && pwrite && !bad_addr;

  // R18 R21 R23 - status and line visibility
  always_comb begin
    status = 32'h0000_0000;
    status[odr_pkg::S_ID]      = plug_id_pin;
    status[odr_pkg::S_AVBUS]   = a_vbus_valid;
    status[odr_pkg::S_BSEND]   = b_sess_end;
    status[odr_pkg::S_ASESS]   = a_sess_valid;
    status[odr_pkg::S_BSESS]   = b_sess_valid;
    status[odr_pkg::S_SE0LONG] = se0_long_r;
    status[odr_pkg::S_SUSPEND] = suspend_r;
    status[odr_pkg::S_SRPDET]  = srp_det_r;
    status[odr_pkg::S_HOST]    = role_host;
    status[odr_pkg::S_SINGLE_ENDED_ZERO_LONG_FLAG] = se0_long_r;
    status[odr_pkg::S_DP]      = dp_in;
    status[odr_pkg::S_DM]      = dm_in;
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      odr_pkg::CTRL_OFS: rd_nxt[odr_pkg::CTRL_W-1:0] = dual_role_control_reg_r;
      odr_pkg::STAT_OFS: rd_nxt = status;
      odr_pkg::EVT_OFS:  rd_nxt[odr_pkg::EVT_W-1:0] = dual_role_event_reg_r;
      odr_pkg::MASK_OFS:
        rd_nxt[odr_pkg::EVT_W-1:0] = dual_role_event_mask_reg_r;
      odr_pkg::TMR_OFS: begin
        rd_nxt[odr_pkg::TMR_W-1:0] = tmr_cnt_r;
        rd_nxt[odr_pkg::T_RUN]     = tmr_run_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle and held through access.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // R11 - control register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dual_role_control_reg_r <= odr_pkg::CTRL_RST;
    end else if (wr_acc && paddr == odr_pkg::CTRL_OFS) begin
      dual_role_control_reg_r <= pwdata[odr_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dual_role_event_mask_reg_r <= odr_pkg::MASK_RST;
    end else if (wr_acc && paddr == odr_pkg::MASK_OFS) begin
      dual_role_event_mask_reg_r <= pwdata[odr_pkg::EVT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drivers; the role follows the plug and VBUS sourcing follows role.
  // R1 R4 - role from plug
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      role_host <= 1'b0;
    end else begin
      role_host <= !plug_id_pin;
    end
  end

  // R2 R4 R5 - VBUS sourcing by role
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vbus_drive_en  <= 1'b0;
      vbus_charge_en <= 1'b0;
      vbus_drain_en  <= 1'b0;
    end else begin
      vbus_drive_en  <= dual_role_control_reg_r[odr_pkg::C_VBUS_DRV]
                        && !plug_id_pin;
      vbus_charge_en <= dual_role_control_reg_r[odr_pkg::C_VBUS_CHG]
                        && plug_id_pin;
      vbus_drain_en  <= dual_role_control_reg_r[odr_pkg::C_VBUS_DRAIN];
    end
  end

  // R3 - B auto connect
  // R16 R17 R19 - pull-up for negotiation
  // R14 - pulsing only on DP
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dp_pullup_en <= 1'b0;
    end else begin
      dp_pullup_en <= dual_role_control_reg_r[odr_pkg::C_DP_PULLUP]
                      || (plug_id_pin && b_sess_valid
                          && !dual_role_control_reg_r[odr_pkg::C_HNP_REL]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ten-microsecond tick shared by the line monitors and the timer.
  // R24 - 10 us base
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= 10'h000;
    end else if (tick) begin
      div_cnt_r <= 10'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 10'h001;
    end
  end
  assign tick = (div_cnt_r == 10'(odr_pkg::TICK_CYC - 1));

  assign se0    = !dp_in && !dm_in;
  assign jstate = dp_in && !dm_in;

  // Long SE0 seen by a B-device before requesting a session.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      se0_cnt_r  <= 10'h000;
      se0_long_r <= 1'b0;
    end else if (!se0) begin
      se0_cnt_r  <= 10'h000;
      se0_long_r <= 1'b0;
    end else if (tick && !se0_long_r) begin
      se0_cnt_r  <= se0_cnt_r + 10'h001;
      se0_long_r <= (se0_cnt_r == 10'(odr_pkg::SE0_LONG_TK - 1));
    end
  end

  // R15 R20 - idle detect for suspend
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_r <= 10'h000;
      suspend_r  <= 1'b0;
    end else if (!jstate) begin
      idle_cnt_r <= 10'h000;
      suspend_r  <= 1'b0;
    end else if (tick && !suspend_r) begin
      idle_cnt_r <= idle_cnt_r + 10'h001;
      suspend_r  <= (idle_cnt_r == 10'(odr_pkg::SUSPEND_TK - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Session-request detector for an A-device not yet powering VBUS.
  // R12 - detection enable
  // R13 - DP or DM pulse
  always_comb begin
    srp_hit = 1'b0;
    if (dual_role_control_reg_r[odr_pkg::C_SRP_EN] && !plug_id_pin
        && !vbus_drive_en) begin
      if (dual_role_control_reg_r[odr_pkg::C_SRP_SEL]) begin
        srp_hit = dp_in || dm_in;
      end else begin
        srp_hit = a_sess_valid && !asess_q_r;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      asess_q_r <= 1'b0;
      srp_det_r <= 1'b0;
    end else begin
      asess_q_r <= a_sess_valid;
      if (srp_hit) begin
        srp_det_r <= 1'b1;
      end else if (!dual_role_control_reg_r[odr_pkg::C_SRP_EN]
                   || vbus_drive_en) begin
        srp_det_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation timer; any write to its register restarts it, run bit arms it.
  // R22 - single restartable timer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tmr_load_r <= '0;
      tmr_cnt_r  <= '0;
      tmr_run_r  <= 1'b0;
    end else if (wr_acc && paddr == odr_pkg::TMR_OFS) begin
      tmr_load_r <= pwdata[odr_pkg::TMR_W-1:0];
      tmr_cnt_r  <= '0;
      tmr_run_r  <= pwdata[odr_pkg::T_RUN];
    end else if (tmr_done) begin
      tmr_run_r <= 1'b0;
    end else if (tmr_run_r && tick) begin
      tmr_cnt_r <= tmr_cnt_r + 16'h0001;
    end
  end
  assign tmr_done = tmr_run_r && (tmr_cnt_r == tmr_load_r);

  ////////////////////////////////////////////////////////////////////////////
  // Events: sticky, write one to clear, a new set beats a clear.
  assign lvl = {b_sess_valid, a_sess_valid, b_sess_end, a_vbus_valid,
                plug_id_pin};

  odr_chg_det #(
    .WIDTH (odr_pkg::CHG_W)
  ) u_chg (
    .clock   (clock),
    .reset_n (reset_n),
    .level   (lvl),
    .changed (lvl_chg)
  );

  // R23 - event sources
  always_comb begin
    evt_set = '0;
    evt_set[odr_pkg::CHG_W-1:0]   = lvl_chg;
    evt_set[odr_pkg::E_SE0LONG]   = tick && se0 && !se0_long_r
        && se0_cnt_r == 10'(odr_pkg::SE0_LONG_TK - 1);
    evt_set[odr_pkg::E_SUSPEND]   = tick && jstate && !suspend_r
        && idle_cnt_r == 10'(odr_pkg::SUSPEND_TK - 1);
    evt_set[odr_pkg::E_RESUME]    = suspend_r && !jstate;
    evt_set[odr_pkg::E_SRPDET]    = srp_hit && !srp_det_r;
    evt_set[odr_pkg::E_TIMER]     = tmr_done;
  end

  always_comb begin
    evt_nxt = dual_role_event_reg_r;
    if (wr_acc && paddr == odr_pkg::EVT_OFS) begin
      evt_nxt = evt_nxt & ~pwdata[odr_pkg::EVT_W-1:0];
    end
    evt_nxt = evt_nxt | evt_set;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dual_role_event_reg_r <= odr_pkg::EVT_RST;
    end else begin
      dual_role_event_reg_r <= evt_nxt;
    end
  end

  // R25 - masked interrupt
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      host_side_irq_pin <= 1'b0;
    end else begin
      host_side_irq_pin <= |(dual_role_event_reg_r
                             & dual_role_event_mask_reg_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_role_follows_id: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1 |=> role_host == !$past(plug_id_pin)) // R1
    else $error("role does not follow plug");

  a_b_no_vbus_drive: assert property (@(posedge clock) disable iff (!reset_n)
    plug_id_pin |=> !vbus_drive_en) // R5
    else $error("B-device drives VBUS");

  a_b_auto_pullup: assert property (@(posedge clock) disable iff (!reset_n)
    plug_id_pin && b_sess_valid
    && !dual_role_control_reg_r[odr_pkg::C_HNP_REL] |=> dp_pullup_en) // R3
    else $error("B-device pull-up missing");

  a_srp_disabled: assert property (@(posedge clock) disable iff (!reset_n)
    !dual_role_control_reg_r[odr_pkg::C_SRP_EN]
    |=> !$rose(srp_det_r)) // R12
    else $error("SRP detected while disabled");

  a_srp_line_dm: assert property (@(posedge clock) disable iff (!reset_n)
    dual_role_control_reg_r[odr_pkg::C_SRP_EN]
    && dual_role_control_reg_r[odr_pkg::C_SRP_SEL] && !plug_id_pin
    && !vbus_drive_en && dm_in |=> srp_det_r) // R13
    else $error("DM pulse not detected");

  a_srp_vbus_sel: assert property (@(posedge clock) disable iff (!reset_n)
    dual_role_control_reg_r[odr_pkg::C_SRP_EN]
    && !dual_role_control_reg_r[odr_pkg::C_SRP_SEL] && !srp_det_r
    && !$rose(a_sess_valid) |=> !srp_det_r) // R11
    else $error("SRP without VBUS pulse");

  a_timer_expiry: assert property (@(posedge clock) disable iff (!reset_n)
    tmr_done && !(wr_acc && paddr == odr_pkg::TMR_OFS)
    |=> dual_role_event_reg_r[odr_pkg::E_TIMER] && !tmr_run_r) // R24
    else $error("timer expiry not flagged");

  a_timer_restart: assert property (@(posedge clock) disable iff (!reset_n)
    wr_acc && paddr == odr_pkg::TMR_OFS |=> tmr_cnt_r == 16'h0000) // R22
    else $error("timer not restarted");

  a_irq_masked: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 host_side_irq_pin == $past(|(dual_role_event_reg_r
                                      & dual_role_event_mask_reg_r))) // R25
    else $error("interrupt does not match masked events");

  a_event_sticky: assert property (@(posedge clock) disable iff (!reset_n)
    dual_role_event_reg_r[odr_pkg::E_SRPDET]
    && !(wr_acc && paddr == odr_pkg::EVT_OFS)
    |=> dual_role_event_reg_r[odr_pkg::E_SRPDET]) // R23
    else $error("event bit lost without clear");

  a_se0_long_flag: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(se0_long_r) |-> $past(se0) && $past(se0, 2)) // R23
    else $error("long SE0 flag without SE0");

  c_srp_seen: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(srp_det_r));
  c_timer_done: cover property (@(posedge clock) disable iff (!reset_n)
    tmr_done);
  c_irq_rise: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(host_side_irq_pin));
  c_suspend: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(suspend_r));
endmodule // odr_session_ctl

// ### verification/odr_far_dev.sv
// Far-side cable partner: VBUS ramp, comparators and line pull-ups.
`timescale 1ns/1ps
module odr_far_dev #(
  parameter int RAMP_MAX = 8
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic vbus_drive_en,
  input  wire logic vbus_charge_en,
  input  wire logic vbus_drain_en,
  input  wire logic dp_pullup_en,
  input  wire logic far_vbus_on,
  input  wire logic far_dp_pu,
  input  wire logic far_dm_pu,
  output logic      a_vbus_valid,
  output logic      a_sess_valid,
  output logic      b_sess_valid,
  output logic      b_sess_end,
  output logic      dp_in,
  output logic      dm_in
);
  int   lvl_r;
  logic src;
  assign src = vbus_drive_en | vbus_charge_en | far_vbus_on;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lvl_r <= 0;
    end else if (src && lvl_r < RAMP_MAX) begin
      lvl_r <= lvl_r + 1;
    end else if (!src && lvl_r > 0) begin
      lvl_r <= (vbus_drain_en && lvl_r > 1) ? lvl_r - 2 : lvl_r - 1;
    end
  end
  assign a_vbus_valid = (lvl_r == RAMP_MAX);
  assign a_sess_valid = (lvl_r >= 6);
  assign b_sess_valid = (lvl_r >= 4);
  assign b_sess_end   = (lvl_r == 0);
  // lines fall to pull-down when released.
  assign dp_in = dp_pullup_en | far_dp_pu;
  assign dm_in = far_dm_pu;
endmodule // odr_far_dev

// ### verification/test_otg_dual_role_session_control.sv
// Self-checking bench of the dual-role session control block.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  fails++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module test_otg_dual_role_session_control;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic        rd_err, plug_id_pin, a_vbus_valid, a_sess_valid;
  logic        b_sess_valid, b_sess_end, dp_in, dm_in, vbus_drive_en;
  logic        vbus_charge_en, vbus_drain_en, dp_pullup_en, role_host;
  logic        host_side_irq_pin, far_vbus_on, far_dp_pu, far_dm_pu;
  int          fails, total_checks;
  odr_session_ctl u_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .plug_id_pin(plug_id_pin), .a_vbus_valid(a_vbus_valid),
    .a_sess_valid(a_sess_valid), .b_sess_valid(b_sess_valid),
    .b_sess_end(b_sess_end), .dp_in(dp_in), .dm_in(dm_in),
    .vbus_drive_en(vbus_drive_en), .vbus_charge_en(vbus_charge_en),
    .vbus_drain_en(vbus_drain_en), .dp_pullup_en(dp_pullup_en),
    .role_host(role_host), .host_side_irq_pin(host_side_irq_pin));
  odr_far_dev u_far (.clock(clock), .reset_n(reset_n),
    .vbus_drive_en(vbus_drive_en), .vbus_charge_en(vbus_charge_en),
    .vbus_drain_en(vbus_drain_en), .dp_pullup_en(dp_pullup_en),
    .far_vbus_on(far_vbus_on), .far_dp_pu(far_dp_pu),
    .far_dm_pu(far_dm_pu), .a_vbus_valid(a_vbus_valid),
    .a_sess_valid(a_sess_valid), .b_sess_valid(b_sess_valid),
    .b_sess_end(b_sess_end), .dp_in(dp_in), .dm_in(dm_in));
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Waits on a condition for at most lim cycles.
  `define WAIT_UNTIL(c, lim) begin int w; \
    for (w = 0; w < (lim) && !(c); w++) @(posedge clock); \
    if (!(c)) begin fails++; end_of_test(); end end
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      end_of_test();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset_values;
    rd(odr_pkg::CTRL_OFS);
    `CHK("ctrl", 32'h0000_0000, rd_data)
    rd(odr_pkg::STAT_OFS);
    `CHK("status", 32'h0000_0005, rd_data)
    rd(odr_pkg::EVT_OFS);
    `CHK("events", 32'h0000_0000, rd_data)
    rd(odr_pkg::MASK_OFS);
    `CHK("mask", 32'h0000_0000, rd_data)
    rd(odr_pkg::TMR_OFS);
    `CHK("timer", 32'h0000_0000, rd_data)
    wr(8'h14, 32'hFFFF_FFFF);
    `CHK("wr err", 1'b1, rd_err)
    rd(8'h14);
    `CHK("rd err", 1'b1, rd_err)
    `CHK("rd gap", 32'h0000_0000, rd_data)
    `CHK("irq", 1'b0, host_side_irq_pin)
  endtask
  task t_roles;
    wr(odr_pkg::CTRL_OFS, 32'h0000_0003);
    tick(4);
    `CHK("b drive", 1'b0, vbus_drive_en)
    `CHK("b charge", 1'b1, vbus_charge_en)
    `CHK("b role", 1'b0, role_host)
    plug_id_pin <= 1'b0;
    `WAIT_UNTIL(a_vbus_valid === 1'b1, 40)
    `CHK("a drive", 1'b1, vbus_drive_en)
    `CHK("a charge", 1'b0, vbus_charge_en)
    `CHK("a role", 1'b1, role_host)
    rd(odr_pkg::STAT_OFS);
    `CHK("a status", 12'h11A, rd_data[11:0])
    wr(odr_pkg::CTRL_OFS, 32'h0000_0000);
    plug_id_pin <= 1'b1;
    `WAIT_UNTIL(b_sess_end === 1'b1, 40)
    `CHK("end drive", 1'b0, vbus_drive_en)
  endtask
  task t_b_pullup;
    far_vbus_on <= 1'b1;
    `WAIT_UNTIL(dp_pullup_en === 1'b1, 40)
    `CHK("b valid", 1'b1, b_sess_valid)
    wr(odr_pkg::CTRL_OFS, 32'h0000_0020);
    tick(3);
    `CHK("release", 1'b0, dp_pullup_en)
    wr(odr_pkg::CTRL_OFS, 32'h0000_0030);
    tick(3);
    `CHK("own pull", 1'b1, dp_pullup_en)
    rd(odr_pkg::STAT_OFS);
    `CHK("dp seen", 1'b1, rd_data[odr_pkg::S_DP])
    wr(odr_pkg::CTRL_OFS, 32'h0000_0004);
    far_vbus_on <= 1'b0;
    tick(3);
    `CHK("drain", 1'b1, vbus_drain_en)
    `WAIT_UNTIL(b_sess_end === 1'b1, 40)
    wr(odr_pkg::CTRL_OFS, 32'h0000_0000);
  endtask
  // short pulses on one far line or on far VBUS, then the flag is read.
  task srp_try(input logic [31:0] c, input logic use_dm,
               input logic use_vb, input logic ex);
    wr(odr_pkg::CTRL_OFS, c);
    far_dm_pu <= use_dm;
    far_dp_pu <= !use_dm && !use_vb;
    far_vbus_on <= use_vb;
    tick(10);
    far_dm_pu <= 1'b0;
    far_dp_pu <= 1'b0;
    far_vbus_on <= 1'b0;
    tick(10);
    rd(odr_pkg::STAT_OFS);
    `CHK("srp flag", ex, rd_data[odr_pkg::S_SRPDET])
    wr(odr_pkg::CTRL_OFS, 32'h0000_0000);
    `WAIT_UNTIL(b_sess_end === 1'b1, 40)
  endtask
  task t_srp;
    plug_id_pin <= 1'b0;
    tick(3);
    wr(odr_pkg::EVT_OFS, 32'h0000_03FF);
    srp_try(32'h0000_0600, 1'b1, 1'b0, 1'b1);
    srp_try(32'h0000_0600, 1'b0, 1'b0, 1'b1);
    srp_try(32'h0000_0200, 1'b1, 1'b0, 1'b0);
    srp_try(32'h0000_0400, 1'b1, 1'b0, 1'b0);
    srp_try(32'h0000_0400, 1'b0, 1'b1, 1'b1);
    rd(odr_pkg::EVT_OFS);
    `CHK("srp evt", 1'b1, rd_data[odr_pkg::E_SRPDET])
  endtask
  task t_timer;
    wr(odr_pkg::EVT_OFS, 32'h0000_03FF);
    wr(odr_pkg::MASK_OFS, 32'h0000_0200);
    wr(odr_pkg::TMR_OFS, 32'h0001_0003);
    rd(odr_pkg::TMR_OFS);
    `CHK("run", 1'b1, rd_data[odr_pkg::T_RUN])
    tick(1900);
    `CHK("early irq", 1'b0, host_side_irq_pin)
    `WAIT_UNTIL(host_side_irq_pin === 1'b1, 3000)
    rd(odr_pkg::TMR_OFS);
    `CHK("expired", 32'h0000_0003, rd_data)
    rd(odr_pkg::EVT_OFS);
    `CHK("tmr evt", 1'b1, rd_data[odr_pkg::E_TIMER])
    wr(odr_pkg::EVT_OFS, 32'h0000_0200);
    tick(3);
    `CHK("cleared", 1'b0, host_side_irq_pin)
    wr(odr_pkg::MASK_OFS, 32'h0000_0000);
    wr(odr_pkg::TMR_OFS, 32'h0001_0001);
    tick(2500);
    rd(odr_pkg::EVT_OFS);
    `CHK("masked evt", 1'b1, rd_data[odr_pkg::E_TIMER])
    `CHK("masked irq", 1'b0, host_side_irq_pin)
  endtask
  // A-device pull-up for negotiation, then a far connect seen as J.
  task t_hnp;
    plug_id_pin <= 1'b0;
    wr(odr_pkg::CTRL_OFS, 32'h0000_0010);
    tick(2);
    `CHK("a pull", 1'b1, dp_pullup_en)
    rd(odr_pkg::STAT_OFS);
    `CHK("j seen", 2'b01, rd_data[11:10])
    wr(odr_pkg::CTRL_OFS, 32'h0000_0000);
    far_dp_pu <= 1'b1;
    tick(2);
    `CHK("a drop", 1'b0, dp_pullup_en)
    rd(odr_pkg::STAT_OFS);
    `CHK("b conn", 2'b01, rd_data[11:10])
    far_dp_pu <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    plug_id_pin = 1'b1;
    far_vbus_on = 1'b0;
    far_dp_pu = 1'b0;
    far_dm_pu = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_reset_values();
    t_roles();
    t_b_pullup();
    t_srp();
    t_timer();
    t_hnp();
    end_of_test();
  end
endmodule // test_otg_dual_role_session_control
